// ==== sas_pkg.sv ====
// Package for the serial audio port: register map, control fields, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package sas_pkg;
  localparam logic [7:0]  SAS_OFF_CTRL_LO  = 8'h00;
  localparam logic [7:0]  SAS_OFF_CTRL_HI  = 8'h04;
  localparam logic [7:0]  SAS_OFF_WLEN     = 8'h08;
  localparam logic [7:0]  SAS_OFF_STATUS   = 8'h0C;
  localparam logic [7:0]  SAS_OFF_MASK     = 8'h10;
  localparam logic [7:0]  SAS_OFF_DATA     = 8'h14;
  localparam logic [15:0] SAS_CTRL_LO_RST  = 16'h0000;
  localparam logic [15:0] SAS_CTRL_HI_RST  = 16'h0000;
  localparam logic [15:0] SAS_MASK_RST     = 16'h0000;
  localparam logic [4:0]  SAS_WLEN_RST     = 5'h00;
  localparam logic [15:0] SAS_CTRL_LO_WMSK = 16'hBFFF;
  // Control low fields
  localparam int SAS_B_PORT_ON     = 15;
  localparam int SAS_B_IDLE_HALT   = 13;
  localparam int SAS_B_OUT_RELEASE = 12;
  localparam int SAS_B_WSEL_UPPER  = 11;
  localparam int SAS_B_WSEL_LOWER  = 10;
  localparam int SAS_B_SAMPLE_PH   = 9;
  localparam int SAS_B_SYNC_EDGE   = 8;
  localparam int SAS_B_SEL_USE     = 7;
  localparam int SAS_B_CLK_POL     = 6;
  localparam int SAS_B_CTRL_ROLE   = 5;
  localparam int SAS_B_REF_CLK     = 2;
  localparam int SAS_B_FIFO_ON     = 0;
  // Control high fields
  localparam int SAS_B_AUDIO_ON    = 15;
  localparam int SAS_B_FRAMED_ON   = 7;
  // Status fields
  localparam int SAS_S_RX_FULL     = 0;
  localparam int SAS_S_RX_EMPTY    = 1;
  localparam int SAS_S_RX_OVF      = 2;
  localparam int SAS_S_RX_WM       = 3;
  localparam int SAS_S_TX_FULL     = 4;
  localparam int SAS_S_TX_EMPTY    = 5;
  localparam int SAS_S_TX_UNDR     = 6;
  localparam int SAS_S_TX_WM       = 7;
  localparam int SAS_S_FRAME_ERR   = 8;
  localparam int SAS_S_ACTIVE      = 9;
  localparam int SAS_S_SR_EMPTY    = 10;
  localparam logic [7:0] SAS_BAUD_DIV_RST = 8'h04;
endpackage

// ==== sas_port.sv ====
// Serial audio port top: APB register slave, word FIFOs, serial shifter.
// Assumes serial pins come from another clock domain; enable pin is synchronous.
//
// Function
// - Single buffer, or FIFO when scheme selected
// - Word length programmable from 2 to 32
// - Audio modes run continuous clock and data
// - Controller drives bit and channel clocks
// - Supports four, three and two pin wiring
// - Receive event from masked receive conditions
// - Transmit event from masked transmit conditions
// - General event from masked frame, busy, empty
// - Controller setup; data write starts transfer
// - Off bit resets, stops clocks, events
// - Idle halt bit stops port in idle
// - Release bit frees serial output pin
// - Non-audio word select 32, 16, 8
// - Audio word select data and channel sizes
// - Audio forces clock-edge bit to zero
// - Framed mode ignores select-pin use
// - Reference clock bit writable only when off
// - Role bit picks controller or target
// - Polarity bit sets clock idle level
// - Edge bit picks transmit launch edge
// - Controller sample phase; target samples middle
`timescale 1ns/1ns
module sas_port #(
  parameter int DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        cpu_idle,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  input  wire logic        shift_clock_pin_i,
  output logic             shift_clock_pin_o,
  output logic             shift_clock_pin_oe,
  input  wire logic        select_or_sync_pin_i,
  output logic             select_or_sync_pin_o,
  output logic             select_or_sync_pin_oe,
  output logic             rx_event_flag,
  output logic             tx_event_flag,
  output logic             general_event_flag
);
  import sas_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rstn = rst_s2_r;

  // Pin synchronisers, two flops each
  logic [2:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else if (clk_en) begin
      pin_s1_r <= {select_or_sync_pin_i, shift_clock_pin_i, serial_in_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire sdi_s = pin_s2_r[0];
  wire sck_s = pin_s2_r[1];
  wire ss_s  = pin_s2_r[2];

  logic [15:0] ctrl_lo_r, ctrl_hi_r, mask_r;
  logic [4:0]  wlen_r;
  wire port_on  = ctrl_lo_r[SAS_B_PORT_ON];
  wire audio_on = ctrl_hi_r[SAS_B_AUDIO_ON];
  wire framed   = ctrl_hi_r[SAS_B_FRAMED_ON] | audio_on;
  wire ctrl_rl  = ctrl_lo_r[SAS_B_CTRL_ROLE];
  wire cpol     = ctrl_lo_r[SAS_B_CLK_POL];
  wire cke      = ctrl_lo_r[SAS_B_SYNC_EDGE] & ~audio_on;
  wire smp_end  = ctrl_lo_r[SAS_B_SAMPLE_PH] & ctrl_rl & ~audio_on;
  wire sel_use  = ctrl_lo_r[SAS_B_SEL_USE] & ~framed;
  wire fifo_on  = ctrl_lo_r[SAS_B_FIFO_ON];
  wire run      = port_on & ~(cpu_idle & ctrl_lo_r[SAS_B_IDLE_HALT]);

  // Word length, 6-bit bit count
  logic [5:0] wbits;
  always_comb begin
    if (!audio_on && wlen_r != 5'h00)
      wbits = {1'b0, wlen_r} + 6'd1;
    else if (!audio_on)
      wbits = ctrl_lo_r[SAS_B_WSEL_UPPER] ? 6'd32 :
              (ctrl_lo_r[SAS_B_WSEL_LOWER] ? 6'd16 : 6'd8);
    else
      unique case (ctrl_lo_r[SAS_B_WSEL_UPPER:SAS_B_WSEL_LOWER])
        2'b11: wbits = 6'd24;
        2'b10: wbits = 6'd32;
        default: wbits = 6'd16;
      endcase
  end
  // Channel slot length in audio mode
  wire [5:0] slot_bits = (audio_on && ctrl_lo_r[SAS_B_WSEL_UPPER:SAS_B_WSEL_LOWER] != 2'b00)
                         ? 6'd32 : wbits;
  wire [5:0] cap = fifo_on ? DEPTH[5:0] : 6'd1;

  // APB decode
  wire acc  = psel & penable;
  wire wr   = acc & pwrite;
  wire rd   = acc & ~pwrite;
  wire hit  = (paddr <= SAS_OFF_DATA) && (paddr[1:0] == 2'b00);
  wire wr_data = wr & (paddr == SAS_OFF_DATA) & port_on;
  wire rd_data = rd & (paddr == SAS_OFF_DATA);

  // FIFOs in flops
  logic [31:0] txm_r [DEPTH];
  logic [31:0] rxm_r [DEPTH];
  logic [AW:0] tx_cnt_r, rx_cnt_r;
  logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic tx_pop, rx_push;
  logic [31:0] rx_word;
  wire tx_full  = {{(5-AW){1'b0}}, tx_cnt_r} >= cap[AW:0] ? 1'b1 : 1'b0;
  wire rx_full  = ({1'b0, rx_cnt_r} >= cap[AW+1:0]);
  wire tx_empty = (tx_cnt_r == '0);
  wire rx_empty = (rx_cnt_r == '0);
  wire tx_push  = wr_data & ~tx_full;
  wire rx_pop   = rd_data & ~rx_empty;
  wire rx_ovf_ev = rx_push & rx_full & ~rx_pop;

  always_ff @(posedge sys_clk) begin
    if (clk_en && tx_push)
      txm_r[tx_wp_r] <= pwdata;
    if (clk_en && rx_push && !(rx_full && !rx_pop))
      rxm_r[rx_wp_r] <= rx_word;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt_r <= '0;
      rx_cnt_r <= '0;
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
    end else if (clk_en) begin
      if (!port_on) begin
        tx_cnt_r <= '0;
        rx_cnt_r <= '0;
        tx_wp_r  <= '0;
        tx_rp_r  <= '0;
        rx_wp_r  <= '0;
        rx_rp_r  <= '0;
      end else begin
        // Occupancy moves in the cycle of push or pop
        tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push & ~rx_ovf_ev) - (AW+1)'(rx_pop);
        if (tx_push) tx_wp_r <= (tx_wp_r == AW'(DEPTH-1)) ? '0 : tx_wp_r + 1'b1;
        if (tx_pop)  tx_rp_r <= (tx_rp_r == AW'(DEPTH-1)) ? '0 : tx_rp_r + 1'b1;
        if (rx_push && !rx_ovf_ev)
          rx_wp_r <= (rx_wp_r == AW'(DEPTH-1)) ? '0 : rx_wp_r + 1'b1;
        if (rx_pop)  rx_rp_r <= (rx_rp_r == AW'(DEPTH-1)) ? '0 : rx_rp_r + 1'b1;
      end
    end
  end

  // Controller bit clock generator
  logic [7:0] baud_cnt_r;
  logic sck_int_r;
  wire baud_tick = (baud_cnt_r == SAS_BAUD_DIV_RST);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      baud_cnt_r <= 8'h00;
    end else if (clk_en) begin
      baud_cnt_r <= (!run || baud_tick) ? 8'h00 : baud_cnt_r + 8'h01;
    end
  end

  // Active-level view of the clock; edges in either role
  logic sck_prev_r;
  wire sck_act  = ctrl_rl ? sck_int_r : (sck_s ^ cpol);
  wire lead_ev  = ctrl_rl ? (baud_tick & ~sck_int_r) : (sck_act & ~sck_prev_r);
  wire trail_ev = ctrl_rl ? (baud_tick & sck_int_r)  : (~sck_act & sck_prev_r);
  wire launch_ev = cke ? trail_ev : lead_ev;
  wire sample_ev = cke ? lead_ev : trail_ev;
  wire sel_ok    = !sel_use || !ss_s || ctrl_rl;

  typedef enum logic [1:0] {
    SAS_IDLE  = 2'b00,
    SAS_SHIFT = 2'b01,
    SAS_ERR   = 2'b10
  } sas_state_e;
  sas_state_e st_r;
  logic [31:0] tsr_r, rsr_r;
  logic [5:0]  bit_r;
  logic        lr_r, smp_pend_r, frm_err_r, tx_undr_r, rx_ovf_r;
  wire active = (st_r == SAS_SHIFT);
  wire start  = run && (st_r == SAS_IDLE) && sel_ok && (!tx_empty || audio_on);
  assign tx_pop  = start & ~tx_empty;
  // The last bit is shifted in at the same edge as the push, so push it alongside
  wire word_done = active && sample_ev && (bit_r == slot_bits - 6'd1) && !smp_end
                   || active && smp_pend_r && launch_ev && (bit_r == slot_bits - 6'd1);
  assign rx_push = word_done;
  assign rx_word = {rsr_r[30:0], sdi_s};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_int_r <= 1'b0;
      sck_prev_r <= 1'b0;
    end else if (clk_en) begin
      sck_prev_r <= sck_act;
      if (!run || (st_r != SAS_SHIFT && !audio_on))
        sck_int_r <= 1'b0;
      else if (baud_tick)
        sck_int_r <= ~sck_int_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= SAS_IDLE;
      tsr_r <= 32'h0000_0000;
      rsr_r <= 32'h0000_0000;
      bit_r <= 6'h00;
      lr_r <= 1'b0;
      smp_pend_r <= 1'b0;
      tx_undr_r <= 1'b0;
    end else if (clk_en) begin
      if (!port_on) begin
        st_r <= SAS_IDLE;
        bit_r <= 6'h00;
        lr_r <= 1'b0;
        smp_pend_r <= 1'b0;
        tx_undr_r <= 1'b0;
      end else begin
        unique case (st_r)
          SAS_IDLE: if (start) begin
            st_r <= SAS_SHIFT;
            bit_r <= 6'h00;
            // Short words must not carry bits of the previous word
            rsr_r <= 32'h0000_0000;
            // Audio with an empty buffer repeats zeros and flags underrun
            tsr_r <= tx_empty ? 32'h0000_0000 : txm_r[tx_rp_r] << (6'd32 - wbits);
            if (tx_empty) tx_undr_r <= 1'b1;
          end
          SAS_SHIFT: begin
            if (launch_ev && bit_r != 6'h00)
              tsr_r <= {tsr_r[30:0], 1'b0};
            if (sample_ev && smp_end)
              smp_pend_r <= 1'b1;
            else if (sample_ev) begin
              rsr_r <= {rsr_r[30:0], sdi_s};
              bit_r <= bit_r + 6'd1;
            end
            if (smp_pend_r && launch_ev) begin
              rsr_r <= {rsr_r[30:0], sdi_s};
              bit_r <= bit_r + 6'd1;
              smp_pend_r <= 1'b0;
            end
            if (word_done) begin
              st_r <= SAS_IDLE;
              lr_r <= ~lr_r;
            end
            if (!ctrl_rl && sel_use && ss_s)
              st_r <= SAS_ERR;
          end
          SAS_ERR: st_r <= SAS_IDLE;
          default: st_r <= SAS_IDLE;
        endcase
      end
    end
  end

  // Sticky error flags; hardware set wins over software clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_ovf_r <= 1'b0;
      frm_err_r <= 1'b0;
    end else if (clk_en) begin
      if (rx_ovf_ev)
        rx_ovf_r <= 1'b1;
      else if (wr && paddr == SAS_OFF_STATUS && pwdata[SAS_S_RX_OVF])
        rx_ovf_r <= 1'b0;
      if (st_r == SAS_ERR)
        frm_err_r <= 1'b1;
      else if (wr && paddr == SAS_OFF_STATUS && pwdata[SAS_S_FRAME_ERR])
        frm_err_r <= 1'b0;
    end
  end

  logic [15:0] stat;
  always_comb begin
    stat = 16'h0000;
    stat[SAS_S_RX_FULL]   = rx_full;
    stat[SAS_S_RX_EMPTY]  = rx_empty;
    stat[SAS_S_RX_OVF]    = rx_ovf_r;
    stat[SAS_S_RX_WM]     = ({1'b0, rx_cnt_r} >= (cap[AW+1:0] >> 1));
    stat[SAS_S_TX_FULL]   = tx_full;
    stat[SAS_S_TX_EMPTY]  = tx_empty;
    stat[SAS_S_TX_UNDR]   = tx_undr_r;
    stat[SAS_S_TX_WM]     = ({1'b0, tx_cnt_r} <= (cap[AW+1:0] >> 1));
    stat[SAS_S_FRAME_ERR] = frm_err_r;
    stat[SAS_S_ACTIVE]    = active;
    stat[SAS_S_SR_EMPTY]  = ~active & tx_empty;
  end
  wire [15:0] ev = stat & mask_r & {16{port_on}};

  // Register writes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_lo_r <= SAS_CTRL_LO_RST;
      ctrl_hi_r <= SAS_CTRL_HI_RST;
      mask_r    <= SAS_MASK_RST;
      wlen_r    <= SAS_WLEN_RST;
    end else if (clk_en && wr) begin
      unique case (paddr)
        SAS_OFF_CTRL_LO: begin
          ctrl_lo_r <= pwdata[15:0] & SAS_CTRL_LO_WMSK;
          if (port_on)
            ctrl_lo_r[SAS_B_REF_CLK] <= ctrl_lo_r[SAS_B_REF_CLK];
        end
        SAS_OFF_CTRL_HI: ctrl_hi_r <= pwdata[15:0];
        SAS_OFF_WLEN:    wlen_r <= pwdata[4:0];
        SAS_OFF_MASK:    mask_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      unique case (paddr)
        SAS_OFF_CTRL_LO: prdata <= {16'h0000, ctrl_lo_r};
        SAS_OFF_CTRL_HI: prdata <= {16'h0000, ctrl_hi_r};
        SAS_OFF_WLEN:    prdata <= {27'h0000000, wlen_r};
        SAS_OFF_STATUS:  prdata <= {16'h0000, stat};
        SAS_OFF_MASK:    prdata <= {16'h0000, mask_r};
        SAS_OFF_DATA:    prdata <= rxm_r[rx_rp_r];
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pin drivers, flopped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      shift_clock_pin_o <= 1'b0;
      shift_clock_pin_oe <= 1'b0;
      select_or_sync_pin_o <= 1'b0;
      select_or_sync_pin_oe <= 1'b0;
      rx_event_flag <= 1'b0;
      tx_event_flag <= 1'b0;
      general_event_flag <= 1'b0;
    end else if (clk_en) begin
      serial_out_pin_o  <= tsr_r[31];
      serial_out_pin_oe <= port_on & ~ctrl_lo_r[SAS_B_OUT_RELEASE];
      shift_clock_pin_o  <= sck_int_r ^ cpol;
      shift_clock_pin_oe <= port_on & ctrl_rl;
      // Controller drives select low while busy, or channel clock in audio
      select_or_sync_pin_o  <= audio_on ? lr_r : ~active;
      select_or_sync_pin_oe <= port_on & ctrl_rl & (framed | ctrl_hi_r[4]);
      rx_event_flag <= |ev[SAS_S_RX_WM:SAS_S_RX_FULL];
      tx_event_flag <= |ev[SAS_S_TX_WM:SAS_S_TX_FULL];
      general_event_flag <= |ev[SAS_S_SR_EMPTY:SAS_S_FRAME_ERR];
    end
  end

endmodule

// ==== sas_port_chk.sv ====
// Checker for the serial audio port: bus answer timing, pin enables, event masks.
// Assumes it is bound to sas_port and sees only that module's ports.
`timescale 1ns/1ns
module sas_port_chk (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        cpu_idle,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_out_pin_oe,
  input wire logic        shift_clock_pin_o,
  input wire logic        shift_clock_pin_oe,
  input wire logic        rx_event_flag,
  input wire logic        tx_event_flag,
  input wire logic        general_event_flag
);
  import sas_pkg::*;
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  logic [15:0] msk_r;
  logic [2:0]  cfg_r;
  logic [2:0]  idl_r;
  logic [3:0]  stb_r;
  logic        sck_r;
  logic        wr;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Shadow of the control and mask words as software last wrote them
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_r  <= SAS_CTRL_LO_RST;
      hi_r  <= SAS_CTRL_HI_RST;
      msk_r <= SAS_MASK_RST;
    end else if (wr) begin
      if (paddr == SAS_OFF_CTRL_LO) lo_r <= pwdata[15:0];
      if (paddr == SAS_OFF_CTRL_HI) hi_r <= pwdata[15:0];
      if (paddr == SAS_OFF_MASK) msk_r <= pwdata[15:0];
    end
  end
  // Settling time after a configuration write, since pin enables are registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= 3'h0;
    end else if (wr && (paddr == SAS_OFF_CTRL_LO || paddr == SAS_OFF_CTRL_HI
                        || paddr == SAS_OFF_MASK)) begin
      cfg_r <= 3'h0;
    end else if (cfg_r != 3'h7) begin
      cfg_r <= cfg_r + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idl_r <= 3'h0;
      stb_r <= 4'h0;
      sck_r <= 1'b0;
    end else begin
      idl_r <= !cpu_idle ? 3'h0 : (idl_r == 3'h7 ? idl_r : idl_r + 3'h1);
      sck_r <= shift_clock_pin_o;
      stb_r <= (cpu_idle || sck_r != shift_clock_pin_o) ? 4'h0 :
               (stb_r == 4'hF ? stb_r : stb_r + 4'h1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  a_slverr_map: assert property (psel && penable && pready |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > SAS_OFF_DATA))
    else $error("error response does not follow address map");
  a_out_pin_release: assert property (cfg_r == 3'h7 |->
    serial_out_pin_oe == (lo_r[SAS_B_PORT_ON] && !lo_r[SAS_B_OUT_RELEASE]))
    else $error("serial out enable wrong");
  a_role_clock_drive: assert property (cfg_r == 3'h7 |->
    shift_clock_pin_oe == (lo_r[SAS_B_PORT_ON] && lo_r[SAS_B_CTRL_ROLE]))
    else $error("shift clock enable wrong");
  a_off_quiet: assert property (cfg_r == 3'h7 && !lo_r[SAS_B_PORT_ON] |->
    !rx_event_flag && !tx_event_flag && !general_event_flag)
    else $error("event while port off");
  a_event_masked: assert property (cfg_r == 3'h7 |->
    (!rx_event_flag || |msk_r[3:0]) && (!tx_event_flag || |msk_r[7:4])
    && (!general_event_flag || |msk_r[10:8]))
    else $error("event raised with its mask clear");
  a_clock_idle_level: assert property (cfg_r == 3'h7 && lo_r[SAS_B_PORT_ON]
    && lo_r[SAS_B_CTRL_ROLE] && !hi_r[SAS_B_AUDIO_ON] && stb_r == 4'hF
    |-> shift_clock_pin_o == lo_r[SAS_B_CLK_POL])
    else $error("resting shift clock at wrong level");
  a_idle_halt_freeze: assert property (lo_r[SAS_B_PORT_ON] && lo_r[SAS_B_IDLE_HALT]
    && idl_r == 3'h7 |-> $stable(shift_clock_pin_o))
    else $error("shift clock moves while halted in idle");
  a_audio_clock_runs: assert property (cfg_r == 3'h7 && lo_r[SAS_B_PORT_ON]
    && lo_r[SAS_B_CTRL_ROLE] && hi_r[SAS_B_AUDIO_ON] && !cpu_idle
    |-> ##[1:12] !$stable(shift_clock_pin_o))
    else $error("audio shift clock not running");
  c_data_write: cover property (wr && paddr == SAS_OFF_DATA);
  c_rx_event: cover property (rx_event_flag);
  c_bus_error: cover property (pready && pslverr);
endmodule
bind sas_port sas_port_chk sas_port_chk_i (.sys_clk, .reset_n, .cpu_idle, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .serial_out_pin_oe, .shift_clock_pin_o,
  .shift_clock_pin_oe, .rx_event_flag, .tx_event_flag, .general_event_flag);

// ==== sas_partner.sv ====
// Serial target model facing the port when the port is the controller.
// Assumes the bench raises active around each word and gives the clock mode.
`timescale 1ns/1ns
module sas_partner (
  input  wire logic        sclk,
  input  wire logic        sdo,
  input  wire logic        active,
  input  wire logic        pol,
  input  wire logic        edge_sel,
  input  wire logic [31:0] reply,
  output logic             sdi,
  output logic [31:0]      got,
  output int               n_bits
);
  int k;
  initial begin
    sdi = 1'b0;
    got = 32'h0;
    n_bits = 0;
    k = 0;
  end
  always @(posedge active) begin
    got = 32'h0;
    n_bits = 0;
    k = 0;
    if (edge_sel) begin
      sdi = reply[31];
      k = 1;
    end
  end
  // A released line must not keep showing the last bit
  always @(negedge active) sdi = ~sdi;
  always @(sclk) begin
    if (active) begin
      if ((sclk != pol) ^ edge_sel) begin
        if (k < 32) sdi = reply[31 - k];
        k++;
      end else begin
        got = {got[30:0], sdo};
        n_bits++;
      end
    end
  end
endmodule

// ==== tb.sv ====
// Testbench for the serial audio port as controller, with a target model.
// Assumes the checker is bound to the port and sas_partner is compiled.
`timescale 1ns/1ns
module tb;
  import sas_pkg::*;
  typedef struct packed {
    logic [1:0] wsel;
    logic [4:0] wlen;
    logic       pol;
    logic       edg;
    logic [5:0] bits;
  } sas_row_s;
  localparam logic [31:0] REPLY = 32'hC3A5_6E19;
  localparam logic [31:0] TXW   = 32'h96E1_5A3C;
  localparam sas_row_s ROWS [6] = '{'{2'h0, 5'h00, 1'b0, 1'b0, 6'h08},
    '{2'h1, 5'h00, 1'b1, 1'b0, 6'h10}, '{2'h2, 5'h00, 1'b0, 1'b1, 6'h20},
    '{2'h3, 5'h00, 1'b1, 1'b1, 6'h20}, '{2'h0, 5'h01, 1'b0, 1'b0, 6'h02},
    '{2'h1, 5'h17, 1'b1, 1'b0, 6'h18}};
  logic        sys_clk, reset_n, clk_en, cpu_idle, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, got, rd, m;
  logic        serial_in_pin, serial_out_pin_o, serial_out_pin_oe, shift_clock_pin_o;
  logic        shift_clock_pin_oe, select_or_sync_pin_o, select_or_sync_pin_oe, err;
  logic        rx_event_flag, tx_event_flag, general_event_flag, act, pol, edg;
  logic        shift_clock_pin_i, select_or_sync_pin_i;
  logic [15:0] cl;
  int          n_errors, num_checks, nb, cyc, sck_n;
  sas_row_s    r;
  // Clock pin rests at idle when nobody drives it; select has a pull-up
  assign shift_clock_pin_i    = shift_clock_pin_oe ? shift_clock_pin_o : pol;
  assign select_or_sync_pin_i = select_or_sync_pin_oe ? select_or_sync_pin_o : 1'b1;
  sas_port #(.DEPTH(8)) sas_port_i (.sys_clk, .reset_n, .clk_en, .cpu_idle, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_in_pin, .serial_out_pin_o,
    .serial_out_pin_oe, .shift_clock_pin_i, .shift_clock_pin_o, .shift_clock_pin_oe,
    .select_or_sync_pin_i, .select_or_sync_pin_o, .select_or_sync_pin_oe, .rx_event_flag,
    .tx_event_flag, .general_event_flag);
  sas_partner sas_partner_i (.sclk(shift_clock_pin_i), .sdo(serial_out_pin_oe ?
    serial_out_pin_o : 1'b1), .active(act), .pol(pol), .edge_sel(edg), .reply(REPLY),
    .sdi(serial_in_pin), .got(got), .n_bits(nb));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) n_errors++;
  endtask
  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      apb(1'b0, SAS_OFF_STATUS, 32'h0);
      n++;
    end while (rd[SAS_S_RX_FULL] !== 1'b1 && n < 400);
    if (n >= 400) n_errors++;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(shift_clock_pin_o) sck_n++;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {reset_n, cpu_idle, psel, penable, pwrite, act, pol, edg} = 8'h00;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b1, SAS_OFF_MASK, 32'h1);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      pol <= r.pol;
      edg <= r.edg;
      m = 32'hFFFF_FFFF >> (32 - r.bits);
      cl = {4'h0, r.wsel, 1'b0, r.edg, 1'b0, r.pol, 1'b1, 5'h00};
      apb(1'b1, SAS_OFF_WLEN, {27'h0, r.wlen});
      apb(1'b1, SAS_OFF_CTRL_LO, {16'h0, cl});
      apb(1'b1, SAS_OFF_STATUS, 32'h4);
      apb(1'b1, SAS_OFF_CTRL_LO, {16'h0, cl | 16'h8000});
      act <= 1'b1;
      apb(1'b1, SAS_OFF_DATA, TXW);
      wait_rx();
      chk("rx_empty", 32'h0, rd[SAS_S_RX_EMPTY]);
      chk("rx_event", 32'h1, rx_event_flag);
      chk("tx_bits", r.bits, nb);
      chk("tx_word", TXW & m, got & m);
      apb(1'b0, SAS_OFF_DATA, 32'h0);
      chk("rx_word", REPLY >> (32 - r.bits), rd);
      act <= 1'b0;
      apb(1'b0, SAS_OFF_STATUS, 32'h0);
      chk("rx_empty", 32'h1, rd[SAS_S_RX_EMPTY]);
      chk("rx_event", 32'h0, rx_event_flag);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, err);
    apb(1'b0, 8'h02, 32'h0);
    chk("slverr", 32'h1, err);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0004);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h8024);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h8020);
    apb(1'b0, SAS_OFF_CTRL_LO, 32'h0);
    chk("ctrl_lo", 32'h8024, rd);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h9020);
    repeat (4) @(posedge sys_clk);
    chk("pin_enables", 32'h1, {serial_out_pin_oe, shift_clock_pin_oe});
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h8000);
    repeat (4) @(posedge sys_clk);
    chk("pin_enables", 32'h2, {serial_out_pin_oe, shift_clock_pin_oe});
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0020);
    pol <= 1'b0;
    edg <= 1'b0;
    apb(1'b1, SAS_OFF_CTRL_LO, 32'hA020);
    cpu_idle <= 1'b1;
    act <= 1'b1;
    apb(1'b1, SAS_OFF_DATA, TXW);
    repeat (8) @(posedge sys_clk);
    sck_n = 0;
    repeat (200) @(posedge sys_clk);
    chk("halted_clock", 32'h0, sck_n);
    cpu_idle <= 1'b0;
    wait_rx();
    chk("rx_full", 32'h1, rd[SAS_S_RX_FULL]);
    act <= 1'b0;
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0020);
    apb(1'b1, SAS_OFF_STATUS, 32'h4);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0021);
    cpu_idle <= 1'b1;
    apb(1'b1, SAS_OFF_CTRL_LO, 32'hA021);
    apb(1'b1, SAS_OFF_DATA, TXW);
    apb(1'b1, SAS_OFF_DATA, TXW);
    apb(1'b0, SAS_OFF_STATUS, 32'h0);
    chk("tx_full", 32'h0, rd[SAS_S_TX_FULL]);
    cpu_idle <= 1'b0;
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0020);
    apb(1'b1, SAS_OFF_CTRL_HI, 32'h8000);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h8120);
    sck_n = 0;
    repeat (100) @(posedge sys_clk);
    chk("audio_clock", 32'h1, sck_n > 0);
    apb(1'b1, SAS_OFF_CTRL_LO, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk("off_outputs", 32'h0, {rx_event_flag, tx_event_flag, general_event_flag,
                               serial_out_pin_oe, shift_clock_pin_oe});
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("reset_outputs", 32'h0, {pready, pslverr, shift_clock_pin_oe});
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (ROWS[i]) begin
      if (i < 4) begin
        apb(1'b0, 8'(i * 4 + (i == 3 ? 4 : 0)), 32'h0);
        chk("reset_value", 32'h0, rd);
      end
    end
    give_verdict();
  end
endmodule
